// ==== hw/i2cms_pkg.sv ====
package i2cms_pkg;
   // register offsets
   localparam logic [15:0] I2CMS_DATA_ADDR = 16'h441e;
   localparam logic [15:0] I2CMS_MODE_ADDR = 16'h442a;
   localparam logic [15:0] I2CMS_SEG_ADDR = 16'h4436;
   localparam logic [15:0] I2CMS_ACK_ADDR = 16'h4438;
   localparam logic [15:0] I2CMS_STAT_ADDR = 16'h443a;
   localparam logic [15:0] I2CMS_IMASK_ADDR = 16'h443c;
   // field positions
   localparam int SEG_START_BIT = 0;
   localparam int SEG_SEND_BIT = 1;
   localparam int SEG_RECV_BIT = 2;
   localparam int SEG_STOP_BIT = 3;
   localparam int ACK_SEL_BIT = 0;
   localparam int STAT_CMD_BIT = 0;
   localparam int STAT_TX_BIT = 1;
   localparam int STAT_RX_BIT = 2;
   localparam int STAT_NACK_BIT = 3;
   localparam int STAT_OVR_BIT = 4;
   localparam int STAT_UDR_BIT = 5;
   localparam int STAT_BUSY_BIT = 6;
   localparam int EV_CMD = 0;
   localparam int EV_NACK = 1;
   localparam int EV_TX = 2;
   localparam int EV_RX = 3;
   localparam int EV_OVR = 4;
   localparam int EV_UDR = 5;
   // values and reset values
   localparam logic [1:0] MODE_I2C = 2'h3;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [3:0] SEG_RST = 4'h0;
   localparam logic [5:0] STAT_RST = 6'h00;
   localparam logic [5:0] IMASK_RST = 6'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // timing: quarter of a bus bit period
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_QUARTER_NS = 625;
   localparam int QUARTER_CYC = (T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_STOP = 2'h1,
      OP_BIT = 2'h2
   } i2cms_op_t;
endpackage : i2cms_pkg

// ==== hw/i2cms_bit_if.sv ====
`timescale 1ns/100ps
interface i2cms_bit_if;
   import i2cms_pkg::*;
   i2cms_op_t op;
   logic go;
   logic wbit;
   logic done;
   logic rbit;
   logic scl_s;
   logic sda_s;
   modport ctrl (output op, output go, output wbit, output scl_s, output sda_s,
      input done, input rbit);
   modport eng (input op, input go, input wbit, input scl_s, input sda_s,
      output done, output rbit);
endinterface : i2cms_bit_if

// ==== hw/i2cms_sync.sv ====
`timescale 1ns/100ps
module i2cms_sync (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [1:0] async_in,
   output logic [1:0] sync_out
);
   logic [1:0] meta_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_reg <= 2'h3;
         sync_out <= 2'h3;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : i2cms_sync

// ==== hw/i2cms_bitgen.sv ====
`timescale 1ns/100ps
module i2cms_bitgen
   import i2cms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   i2cms_bit_if.eng bif,
   output logic scl_oe_n,
   output logic sda_oe_n
);
   logic busy_reg;
   i2cms_op_t op_reg;
   logic wbit_reg;
   logic [1:0] phase_reg;
   logic [6:0] cnt_reg;
   logic done_reg;
   logic rbit_reg;
   // phase 1 waits for the line to really go high (slave stretching)
   wire stretch = (phase_reg == 2'h1) && !bif.scl_s;
   wire tick = busy_reg && (cnt_reg == QUARTER_LAST) && !stretch;
   wire launch = bif.go && !busy_reg;
   wire [1:0] ph_now = launch ? 2'h0 : phase_reg;
   wire i2cms_op_t op_now = launch ? bif.op : op_reg;
   wire wb_now = launch ? bif.wbit : wbit_reg;
   wire act = launch || busy_reg;
   // phase 0 keeps the clock line as it is
   wire scl_pull = (ph_now == 2'h0) ? !scl_oe_n :
      (ph_now == 2'h3) && (op_now != OP_STOP);
   wire sda_pull = (op_now == OP_BIT) ? !wb_now :
      (op_now == OP_START) ? ph_now[1] : !ph_now[1];
   assign bif.done = done_reg;
   assign bif.rbit = rbit_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_reg <= 1'b0;
         op_reg <= OP_START;
         wbit_reg <= 1'b1;
         phase_reg <= 2'h0;
         cnt_reg <= 7'h00;
         done_reg <= 1'b0;
         rbit_reg <= 1'b1;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         done_reg <= tick && (phase_reg == 2'h3);
         if (launch) begin
            busy_reg <= 1'b1;
            op_reg <= bif.op;
            wbit_reg <= bif.wbit;
            phase_reg <= 2'h0;
            cnt_reg <= 7'h00;
         end else if (tick) begin
            busy_reg <= (phase_reg != 2'h3);
            phase_reg <= phase_reg + 2'h1;
            cnt_reg <= 7'h00;
         end else if (busy_reg && !stretch) begin
            cnt_reg <= cnt_reg + 7'h01;
         end
         if (tick && (phase_reg == 2'h2)) begin
            rbit_reg <= bif.sda_s;
         end
         if (act) begin
            scl_oe_n <= !scl_pull;
            sda_oe_n <= !sda_pull;
         end
      end
   end
endmodule : i2cms_bitgen

// ==== hw/i2cms_top.sv ====
// Function
// - receive ends with ack or nack per select
// - data write pushes tx, read pops rx
// - receive clocks eight bits msb first, then ack
// - stop request generates a stop condition
// - no request means bus left untouched
// - one-byte receive and transmit buffers
// - start and stop requests self-clear when done
// - command done flag for start and stop
// - transmit done flag after send segment
// - receive done flag after receive segment
// - status shows ack or nack of slot
// - event on command done rising edge
// - event on transmitted byte answered nack
// - event on transmit done rising edge
// - event on receive done rising edge
// - receive overrun flagged, byte discarded
// - transmit underrun flagged on empty send
// - events pass only when both masks enable
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module i2cms_top
   import i2cms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic top_irq_enable,
   output logic [5:0] irq_event,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_CMD = 4'h2,
      S_BITS = 4'h4,
      S_ACK = 4'h8
   } i2cms_state_t;

   // one bit operation goes to the engine, its result comes back
   i2cms_bit_if bif ();

   // sequencer state, control fields and the one-byte buffers
   i2cms_state_t state_reg;
   i2cms_state_t state_next;
   logic [1:0] mode_reg;
   logic [3:0] seg_reg;
   logic [3:0] seg_next;
   logic ack_sel_reg;
   logic [5:0] imask_reg;
   logic [5:0] stat_reg;
   logic [5:0] stat_next;
   logic [5:0] stat_set;
   logic nack_ev;
   logic [7:0] tx_data_reg;
   logic tx_full_reg;
   logic tx_full_next;
   logic [7:0] rx_data_reg;
   logic [7:0] rx_data_next;
   logic rx_full_reg;
   logic rx_full_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [2:0] bitcnt_reg;
   logic [2:0] bitcnt_next;
   logic is_recv_reg;
   logic is_recv_next;
   logic go_reg;
   logic go_next;
   i2cms_op_t op_reg;
   i2cms_op_t op_next;
   logic wbit_reg;
   logic wbit_next;
   logic [15:0] rdata_reg;
   logic [5:0] irq_reg;
   logic [1:0] pins_sync;

   // bus pin inputs pass two flops first
   i2cms_sync u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({scl_in, sda_in}),
      .sync_out(pins_sync)
   );

   i2cms_bitgen u_bitgen (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .bif(bif),
      .scl_oe_n(scl_oe_n),
      .sda_oe_n(sda_oe_n)
   );

   assign bif.scl_s = pins_sync[1];
   assign bif.sda_s = pins_sync[0];
   assign bif.go = go_reg;
   assign bif.op = op_reg;
   assign bif.wbit = wbit_reg;
   // open-drain lines only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign reg_rdata = rdata_reg;
   assign irq_event = irq_reg;

   // one address compare per register, shared by write decode and read mux
   wire hit_data = (reg_addr == I2CMS_DATA_ADDR);
   wire hit_mode = (reg_addr == I2CMS_MODE_ADDR);
   wire hit_seg = (reg_addr == I2CMS_SEG_ADDR);
   wire hit_ack = (reg_addr == I2CMS_ACK_ADDR);
   wire hit_stat = (reg_addr == I2CMS_STAT_ADDR);
   wire hit_imask = (reg_addr == I2CMS_IMASK_ADDR);

   // register decode
   wire wr_data = reg_wr && hit_data;
   wire wr_mode = reg_wr && hit_mode;
   wire wr_seg = reg_wr && hit_seg;
   wire wr_ack = reg_wr && hit_ack;
   wire wr_stat = reg_wr && hit_stat;
   wire wr_imask = reg_wr && hit_imask;
   wire rd_data = reg_rd && hit_data;
   wire idle = (state_reg == S_IDLE);
   wire master_on = (mode_reg == MODE_I2C);

   // exactly one request bit selects a segment
   wire one_req = (seg_reg != 4'h0) && ((seg_reg & (seg_reg - 4'h1)) == 4'h0);
   wire can_issue = idle && master_on && one_req && !go_reg;
   wire req_start = can_issue && seg_reg[SEG_START_BIT];
   wire req_stop = can_issue && seg_reg[SEG_STOP_BIT];
   wire req_send = can_issue && seg_reg[SEG_SEND_BIT];
   wire req_recv = can_issue && seg_reg[SEG_RECV_BIT];

   // status flags clear by writing one; a set in the same cycle wins
   // nack seen follows each slot, so software cannot clear it
   wire [5:0] stat_clr = wr_stat ? reg_wdata[5:0] : 6'h00;
   wire [5:0] stat_w1c = stat_clr & ~(6'h01 << STAT_NACK_BIT);
   wire [5:0] stat_rise = stat_next & ~stat_reg;

   // read mux; unmapped offsets read zero
   wire [15:0] rd_mux =
      hit_data ? {8'h00, rx_data_reg} :
      hit_mode ? {14'h0000, mode_reg} :
      hit_seg ? {12'h000, seg_reg} :
      hit_ack ? {15'h0000, ack_sel_reg} :
      hit_stat ? {9'h000, !idle, stat_reg} :
      hit_imask ? {10'h000, imask_reg} :
      16'h0000;

   // interrupt events
   wire [5:0] ev_vec = {
      stat_set[STAT_UDR_BIT],
      stat_set[STAT_OVR_BIT],
      stat_rise[STAT_RX_BIT],
      stat_rise[STAT_TX_BIT],
      nack_ev,
      stat_rise[STAT_CMD_BIT]
   };
   wire [5:0] irq_next = ev_vec & imask_reg & {6{top_irq_enable}};

   always_comb begin
      state_next = state_reg;
      seg_next = seg_reg;
      stat_set = 6'h00;
      nack_ev = 1'b0;
      tx_full_next = tx_full_reg;
      rx_data_next = rx_data_reg;
      rx_full_next = rx_full_reg;
      shift_next = shift_reg;
      bitcnt_next = bitcnt_reg;
      is_recv_next = is_recv_reg;
      go_next = 1'b0;
      op_next = op_reg;
      wbit_next = wbit_reg;
      // requests are taken only while no segment runs
      if (wr_seg && idle) begin
         seg_next = reg_wdata[3:0];
      end
      if (wr_data) begin
         tx_full_next = 1'b1;
      end
      if (rd_data) begin
         rx_full_next = 1'b0;
      end
      case (state_reg)
         S_IDLE: begin
            if (req_start || req_stop) begin
               go_next = 1'b1;
               op_next = req_start ? OP_START : OP_STOP;
               state_next = S_CMD;
            end else if (req_send) begin
               go_next = 1'b1;
               op_next = OP_BIT;
               // an empty buffer still sends its stale byte
               wbit_next = tx_data_reg[7];
               shift_next = tx_data_reg;
               tx_full_next = wr_data;
               stat_set[STAT_UDR_BIT] = !tx_full_reg;
               bitcnt_next = 3'h0;
               is_recv_next = 1'b0;
               state_next = S_BITS;
            end else if (req_recv) begin
               go_next = 1'b1;
               op_next = OP_BIT;
               wbit_next = 1'b1;
               bitcnt_next = 3'h0;
               is_recv_next = 1'b1;
               state_next = S_BITS;
            end
         end
         S_CMD: begin
            if (bif.done) begin
               seg_next = SEG_RST;
               stat_set[STAT_CMD_BIT] = 1'b1;
               state_next = S_IDLE;
            end
         end
         S_BITS: begin
            if (bif.done) begin
               // msb first; the sampled line fills from the bottom
               shift_next = {shift_reg[6:0], bif.rbit};
               // the next bit operation follows at once
               go_next = 1'b1;
               op_next = OP_BIT;
               if (bitcnt_reg == 3'h7) begin
                  // ack select high drives an acknowledge
                  wbit_next = is_recv_reg ? !ack_sel_reg : 1'b1;
                  state_next = S_ACK;
               end else begin
                  bitcnt_next = bitcnt_reg + 3'h1;
                  wbit_next = is_recv_reg ? 1'b1 : shift_reg[6];
               end
            end
         end
         S_ACK: begin
            if (bif.done) begin
               seg_next = SEG_RST;
               stat_set[STAT_NACK_BIT] = bif.rbit;
               if (is_recv_reg) begin
                  stat_set[STAT_RX_BIT] = 1'b1;
                  // a data port read in this very cycle frees the buffer in time
                  if (rx_full_reg && !rd_data) begin
                     stat_set[STAT_OVR_BIT] = 1'b1;
                  end else begin
                     rx_data_next = shift_reg;
                     rx_full_next = 1'b1;
                  end
               end else begin
                  stat_set[STAT_TX_BIT] = 1'b1;
                  nack_ev = bif.rbit;
               end
               state_next = S_IDLE;
            end
         end
         default: begin
            // an illegal state code falls back to idle
            state_next = S_IDLE;
         end
      endcase
      stat_next = (stat_reg & ~stat_w1c) | stat_set;
      // nack status follows each acknowledge slot
      if (state_reg == S_ACK && bif.done) begin
         stat_next[STAT_NACK_BIT] = bif.rbit;
      end
   end

   // control fields and sticky status
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= S_IDLE;
         mode_reg <= MODE_RST;
         seg_reg <= SEG_RST;
         ack_sel_reg <= 1'b0;
         imask_reg <= IMASK_RST;
         stat_reg <= STAT_RST;
      end else begin
         state_reg <= state_next;
         seg_reg <= seg_next;
         stat_reg <= stat_next;
         if (wr_mode) begin
            mode_reg <= reg_wdata[1:0];
         end
         if (wr_ack) begin
            ack_sel_reg <= reg_wdata[ACK_SEL_BIT];
         end
         if (wr_imask) begin
            imask_reg <= reg_wdata[5:0];
         end
      end
   end

   // data path: one-byte buffers and the shifter
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_data_reg <= DATA_RST;
         tx_full_reg <= 1'b0;
         rx_data_reg <= DATA_RST;
         rx_full_reg <= 1'b0;
         shift_reg <= DATA_RST;
         bitcnt_reg <= 3'h0;
         is_recv_reg <= 1'b0;
      end else begin
         if (wr_data) begin
            tx_data_reg <= reg_wdata[7:0];
         end
         tx_full_reg <= tx_full_next;
         rx_data_reg <= rx_data_next;
         rx_full_reg <= rx_full_next;
         shift_reg <= shift_next;
         bitcnt_reg <= bitcnt_next;
         is_recv_reg <= is_recv_next;
      end
   end

   // registered strobes to the engine, read data and event pulses
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         go_reg <= 1'b0;
         op_reg <= OP_START;
         wbit_reg <= 1'b1;
         rdata_reg <= 16'h0000;
         irq_reg <= 6'h00;
      end else begin
         go_reg <= go_next;
         op_reg <= op_next;
         wbit_reg <= wbit_next;
         rdata_reg <= reg_rd ? rd_mux : 16'h0000;
         irq_reg <= irq_next;
      end
   end
endmodule : i2cms_top

// ==== dv/i2cms_slave_model.sv ====
`timescale 1ns/100ps
module i2cms_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic rd_mode,
   input wire logic give_nack,
   input wire logic [7:0] rd_byte,
   output logic sda_oe_n
);
   int bit_cnt = 0;
   int slot = 0;
   logic active = 1'b0;
   // start or repeated start restarts the byte count
   always @(negedge sda) begin
      if (scl) begin
         active = 1'b1;
         bit_cnt = 0;
         slot = 0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         active = 1'b0;
      end
   end
   // nine clocks per byte, the last one is the ack slot
   always @(posedge scl) begin
      bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
   end
   // output changes only while the clock line is low
   always @(negedge scl) begin
      slot = bit_cnt;
   end
   // released line goes high through the pull-up
   assign sda_oe_n = !active ? 1'b1 : (slot == 8) ? (rd_mode | give_nack) :
      (!rd_mode | rd_byte[7 - slot]);
endmodule : i2cms_slave_model

// ==== dv/i2cms_top_sva.sv ====
`timescale 1ns/100ps
module i2cms_top_sva
   import i2cms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic top_irq_enable,
   input wire logic [5:0] irq_event,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] mode_reg;
   logic [5:0] mask_reg;
   logic [15:0] since_reg;
   wire seg_wr = reg_wr && reg_addr == I2CMS_SEG_ADDR;
   wire cmd_wr = seg_wr && (reg_wdata[SEG_START_BIT] || reg_wdata[SEG_STOP_BIT]);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_reg <= MODE_RST;
         mask_reg <= IMASK_RST;
         since_reg <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == I2CMS_MODE_ADDR) mode_reg <= reg_wdata[1:0];
         if (reg_wr && reg_addr == I2CMS_IMASK_ADDR) mask_reg <= reg_wdata[5:0];
         since_reg <= cmd_wr ? 16'h0000 : since_reg + 16'(since_reg != 16'hffff);
      end
   end
   sequence start_req;
      seg_wr && reg_wdata[3:0] == 4'h1 && mode_reg == MODE_I2C;
   endsequence
   sequence stop_req;
      seg_wr && reg_wdata[3:0] == 4'h8 && mode_reg == MODE_I2C;
   endsequence
   chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_mode_gate: assert property (mode_reg != MODE_I2C |-> $stable({scl_oe_n, sda_oe_n}))
      else $error("bus moved outside master mode");
   chk_start_cond: assert property (start_req |-> ##[120:135] ($fell(sda_oe_n) && scl_oe_n))
      else $error("start condition missing");
   chk_stop_cond: assert property (stop_req |-> ##[120:135] ($rose(sda_oe_n) && scl_oe_n))
      else $error("stop condition missing");
   chk_cmd_event: assert property (irq_event[EV_CMD] |-> since_reg inside {[245:265]})
      else $error("command event at wrong time");
   chk_event_pulse: assert property ((irq_event & $past(irq_event)) == 6'h00)
      else $error("event longer than one cycle");
   chk_top_mask: assert property (!top_irq_enable && !$past(top_irq_enable) |-> irq_event == 6'h00)
      else $error("event with top mask off");
   chk_imask_gate: assert property ((irq_event & ~mask_reg) == 6'h00)
      else $error("event with controller mask off");
endmodule : i2cms_top_sva
bind i2cms_top i2cms_top_sva chk_u (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .top_irq_enable, .irq_event, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out,
   .sda_oe_n);

// ==== dv/i2cms_top_tb.sv ====
`timescale 1ns/100ps
module i2cms_top_tb
   import i2cms_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic top_irq_enable = 1'b1;
   logic rd_mode = 1'b0;
   logic give_nack = 1'b0;
   logic [7:0] rd_byte = 8'h00;
   logic [15:0] reg_rdata;
   logic [5:0] irq_event;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, slv_oe_n;
   logic [8:0] wire_bits = 9'h000;
   int ev_cnt [6] = '{default: 0};
   int errors = 0;
   int total_checks = 0;
   // both lines pulled up, low while any party drives
   wire scl_w = scl_oe_n;
   wire sda_w = sda_oe_n & slv_oe_n;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) ev_cnt[i] += int'(irq_event[i]);
   end
   always @(posedge scl_w) wire_bits <= {wire_bits[7:0], sda_w};
   i2cms_top dut_u (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .top_irq_enable, .irq_event, .scl_in(scl_w), .scl_out, .scl_oe_n, .sda_in(sda_w),
      .sda_out, .sda_oe_n);
   i2cms_slave_model slave_u (.scl(scl_w), .sda(sda_w), .rd_mode, .give_nack, .rd_byte,
      .sda_oe_n(slv_oe_n));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // issue one segment, wait for its request to clear, check and clear the status
   task automatic seg(input int b, input logic [6:0] exp);
      logic [15:0] d;
      int n;
      wr(I2CMS_SEG_ADDR, 16'h0001 << b);
      n = 0;
      d = 16'h000f;
      while (d[3:0] !== 4'h0 && n < 4000) begin
         rd(I2CMS_SEG_ADDR, d);
         n++;
      end
      chk(d, 16'h0000);
      rd(I2CMS_STAT_ADDR, d);
      chk(d, {9'h000, exp});
      wr(I2CMS_STAT_ADDR, 16'h003f);
   endtask : seg
   task automatic t_reset;
      logic [15:0] d;
      logic [15:0] al [7] = '{I2CMS_DATA_ADDR, I2CMS_MODE_ADDR, I2CMS_SEG_ADDR,
         I2CMS_ACK_ADDR, I2CMS_STAT_ADDR, I2CMS_IMASK_ADDR, 16'h4400};
      foreach (al[i]) begin
         rd(al[i], d);
         chk(d, 16'h0000);
      end
      chk(16'({scl_oe_n, sda_oe_n}), 16'h0003);
      chk(16'({scl_out, sda_out}), 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_mode;
      logic [15:0] d;
      wr(I2CMS_SEG_ADDR, 16'h0001);
      repeat (300) @(posedge core_clk);
      rd(I2CMS_SEG_ADDR, d);
      chk(d, 16'h0001);
      chk(16'({scl_oe_n, sda_oe_n}), 16'h0003);
      wr(I2CMS_SEG_ADDR, 16'h0000);
      wr(I2CMS_MODE_ADDR, 16'h0003);
      wr(I2CMS_SEG_ADDR, 16'h0003);
      repeat (300) @(posedge core_clk);
      rd(I2CMS_SEG_ADDR, d);
      chk(d, 16'h0003);
      chk(16'({scl_oe_n, sda_oe_n}), 16'h0003);
      wr(I2CMS_SEG_ADDR, 16'h0000);
      $display("test mode done");
   endtask : t_mode
   task automatic t_send;
      wr(I2CMS_IMASK_ADDR, 16'h003f);
      seg(SEG_START_BIT, 7'h01);
      chk(16'({scl_oe_n, sda_oe_n}), 16'h0000);
      wr(I2CMS_DATA_ADDR, 16'h00a5);
      seg(SEG_SEND_BIT, 7'h02);
      chk(16'(wire_bits), 16'h014a);
      give_nack <= 1'b1;
      seg(SEG_SEND_BIT, 7'h2a);
      chk(16'(wire_bits), 16'h014b);
      give_nack <= 1'b0;
      $display("test send done");
   endtask : t_send
   task automatic t_recv;
      logic [15:0] d;
      rd_byte <= 8'h3c;
      rd_mode <= 1'b1;
      wr(I2CMS_ACK_ADDR, 16'h0001);
      seg(SEG_RECV_BIT, 7'h04);
      chk(16'(wire_bits), 16'h0078);
      rd_byte <= 8'hc3;
      wr(I2CMS_ACK_ADDR, 16'h0000);
      seg(SEG_RECV_BIT, 7'h1c);
      chk(16'(wire_bits), 16'h0187);
      rd(I2CMS_DATA_ADDR, d);
      chk(d, 16'h003c);
      rd_mode <= 1'b0;
      $display("test receive done");
   endtask : t_recv
   task automatic t_stop_mask;
      int ev_exp [6] = '{2, 1, 2, 2, 1, 1};
      seg(SEG_STOP_BIT, 7'h09);
      chk(16'({scl_oe_n, sda_oe_n, scl_w, sda_w}), 16'h000f);
      wr(I2CMS_IMASK_ADDR, 16'h0000);
      seg(SEG_START_BIT, 7'h09);
      wr(I2CMS_IMASK_ADDR, 16'h003f);
      top_irq_enable <= 1'b0;
      seg(SEG_STOP_BIT, 7'h09);
      top_irq_enable <= 1'b1;
      foreach (ev_exp[i]) chk(16'(ev_cnt[i]), 16'(ev_exp[i]));
      $display("test stop and mask done");
   endtask : t_stop_mask
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_mode();
      t_send();
      t_recv();
      t_stop_mask();
      test_done();
   end
   initial begin
      #400000;
      errors++;
      test_done();
   end
endmodule : i2cms_top_tb
